// ==== uart_pkg.sv ====
// Purpose: Shared constants and types for the address-detecting serial port.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
package uart_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_DATA    = 8'h00;
  localparam logic [7:0] OFF_DIV_LO  = 8'h04;
  localparam logic [7:0] OFF_DIV_HI  = 8'h08;
  localparam logic [7:0] OFF_CTRL    = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h14;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h18;
  localparam logic [7:0] OFF_ADDR    = 8'h1c;

  // ----------------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------------
  localparam int CTL_LEN_LO   = 0;  // Two bits: data length minus five.
  localparam int CTL_STOP2    = 2;
  localparam int CTL_PAR_EN   = 3;
  localparam int CTL_PAR_ODD  = 4;
  localparam int CTL_NINE     = 5;
  localparam int CTL_DMA      = 6;
  localparam int CTL_ADDR_DET = 7;
  localparam int CTL_W        = 8;

  // Interrupt bit positions.
  localparam int IRQ_TX_EMPTY = 0;
  localparam int IRQ_RX_READY = 1;
  localparam int IRQ_RX_ERR   = 2;
  localparam int IRQ_W        = 3;

  // Timing constants.
  localparam logic [3:0]  OVERSAMPLE_LAST = 4'hf;  // Sixteen ticks a bit.
  localparam logic [3:0]  MID_TICK        = 4'h7;
  localparam logic [15:0] DIV_RESET       = 16'h0001;
  localparam logic [3:0]  BASE_LEN        = 4'h5;

  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_NINTH, S_STOP} frame_state_t;

  typedef struct packed {
    logic [3:0] len;
    logic       stop2;
    logic       par_en;
    logic       par_odd;
    logic       nine;
  } frame_cfg_t;

  typedef struct packed {
    logic       sel;
    logic       en;
    logic       wr;
    logic [7:0] addr;
  } apb_req_t;

endpackage : uart_pkg

// ==== uart_port.sv ====
// Purpose: Full-duplex serial port with address detect, DMA requests and IRQ.
// Assumes: pclk at 100 MHz; rxd is asynchronous to pclk.
// Notes:   Rx and tx run separately, each with holding and shift registers.
//
// Notes on behaviour
// - Data length selectable five to eight bits per frame.
// - One or two stop bits sent; receiver checks only the first stop bit.
// - Parity none, even or odd; inserted on send, checked on receive.
// - Whole frame spans seven to twelve bit periods.
// - Bit rate from clock over 1048576 down to clock over 16.
// - Divisor is sixteen bits, high byte register joined to low byte.
// - Nine-bit mode: extra bit marks address characters for detection.
// - Programmed mode double buffers both transmit and receive.
// - Processor moves characters through the memory-mapped data register.
// - DMA mode raises separate transmit and receive request lines.
// - Port DMA requests carry a low default priority flag.
// - Tx and rx events raise individually maskable interrupts.
// - Transmit and receive run concurrently and independently.
// - Synchronised receive line is exported for timer baud measurement.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module uart_port (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial lines
  input  wire logic        rxd,
  output logic             txd,
  // DMA handshake
  output logic             dma_tx_req,
  output logic             dma_rx_req,
  output logic             dma_low_prio,
  // Timer link and interrupt
  output logic             rx_level,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------------
  logic [7:0]                  div_lo_q, div_hi_q, addr_q;
  logic [uart_pkg::CTL_W-1:0]  ctrl_q;
  logic [uart_pkg::IRQ_W-1:0]  ist_q, imsk_q, ev;
  uart_pkg::apb_req_t          req;
  uart_pkg::frame_cfg_t        cfg;
  logic [15:0]                 div;
  logic                        acc, wr, rd, mapped;

  assign req    = '{sel: psel, en: penable, wr: pwrite, addr: paddr};
  assign acc    = req.sel && req.en;
  assign wr     = acc && req.wr;
  assign rd     = acc && !req.wr;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= uart_pkg::OFF_ADDR);
  assign div    = {div_hi_q, div_lo_q};
  // One aggregate keeps the frame settings under a single driver.
  // length field
  assign cfg = '{len:     uart_pkg::BASE_LEN + {2'b00, ctrl_q[uart_pkg::CTL_LEN_LO+:2]},
                 stop2:   ctrl_q[uart_pkg::CTL_STOP2],
                 par_en:  ctrl_q[uart_pkg::CTL_PAR_EN],
                 par_odd: ctrl_q[uart_pkg::CTL_PAR_ODD],
                 nine:    ctrl_q[uart_pkg::CTL_NINE]};
  logic dma_mode;
  assign dma_mode = ctrl_q[uart_pkg::CTL_DMA];

  // ----------------------------------------------------------------------
  // Baud tick: one tick per divisor count, sixteen ticks a bit
  // ----------------------------------------------------------------------
  logic [15:0] bcnt_q;
  logic        tick;
  assign tick = (bcnt_q == 16'h0001) || (div == 16'h0001);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_q <= uart_pkg::DIV_RESET;
    end else if (tick) begin
      bcnt_q <= div;  // Zero reloads zero and counts 65536 steps.
    end else begin
      bcnt_q <= bcnt_q - 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------------
  logic [8:0]            thr_q, tsr_q;
  logic                  thr_full_q, txd_q, tpar_q, t9_q;
  logic [3:0]            ttick_q, tbit_q;
  uart_pkg::frame_state_t tst_q;
  logic                  data_wr, tx_load, tbit_end;
  assign data_wr  = wr && (paddr == uart_pkg::OFF_DATA);
  assign tx_load  = (tst_q == uart_pkg::S_IDLE) && thr_full_q && tick;
  assign tbit_end = tick && (ttick_q == uart_pkg::OVERSAMPLE_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_q      <= '0;
      thr_full_q <= 1'b0;
    end else if (data_wr) begin
      thr_q      <= pwdata[8:0];
      thr_full_q <= 1'b1;
    end else if (tx_load) begin
      thr_full_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tst_q   <= uart_pkg::S_IDLE;
      tsr_q   <= '0;
      txd_q   <= 1'b1;
      ttick_q <= '0;
      tbit_q  <= '0;
      tpar_q  <= 1'b0;
      t9_q    <= 1'b0;
    end else begin
      if (tst_q != uart_pkg::S_IDLE && tick) ttick_q <= ttick_q + 4'h1;
      case (tst_q)
        uart_pkg::S_IDLE: begin
          txd_q <= 1'b1;
          if (tx_load) begin
            // The ninth bit is latched here, so a new holding write cannot alter a frame in flight.
            tsr_q   <= thr_q;
            t9_q    <= thr_q[8];
            tst_q   <= uart_pkg::S_START;
            txd_q   <= 1'b0;
            ttick_q <= '0;
            tbit_q  <= '0;
            tpar_q  <= cfg.par_odd;
          end
        end
        uart_pkg::S_START: if (tbit_end) begin
          tst_q <= uart_pkg::S_DATA;
          txd_q <= tsr_q[0];
        end
        uart_pkg::S_DATA: if (tbit_end) begin
          tpar_q <= tpar_q ^ tsr_q[0];
          tsr_q  <= {1'b0, tsr_q[8:1]};
          tbit_q <= tbit_q + 4'h1;
          if (tbit_q + 4'h1 == cfg.len) begin
            if (cfg.par_en) begin
              tst_q <= uart_pkg::S_PAR;
              txd_q <= tpar_q ^ tsr_q[0];
            end else if (cfg.nine) begin
              tst_q <= uart_pkg::S_NINTH;
              txd_q <= t9_q;
            end else begin
              tst_q  <= uart_pkg::S_STOP;
              txd_q  <= 1'b1;
              tbit_q <= '0;
            end
          end else begin
            txd_q <= tsr_q[1];
          end
        end
        uart_pkg::S_PAR, uart_pkg::S_NINTH: if (tbit_end) begin
          tst_q  <= uart_pkg::S_STOP;
          txd_q  <= 1'b1;
          tbit_q <= '0;
        end
        uart_pkg::S_STOP: if (tbit_end) begin
          if (cfg.stop2 && tbit_q == 4'h0) tbit_q <= 4'h1;
          else tst_q <= uart_pkg::S_IDLE;
        end
        default: tst_q <= uart_pkg::S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------------
  logic                  rx_m_q, rx_s_q;
  logic [8:0]            rsr_q, rbr_q;
  logic                  rbr_full_q, rpar_q, r9_q;
  logic                  perr_q, ferr_q, oerr_q;
  logic [3:0]            rtick_q, rbit_q;
  uart_pkg::frame_state_t rst_q;
  logic                  rsamp, data_rd, rx_done, rx_ok_d, pbad, fbad, addr_hit;
  assign rsamp    = tick && (rtick_q == uart_pkg::MID_TICK);
  assign data_rd  = rd && (paddr == uart_pkg::OFF_DATA);
  assign rx_done  = (rst_q == uart_pkg::S_STOP) && rsamp;
  assign pbad     = cfg.par_en && (rpar_q != cfg.par_odd);
  assign fbad     = !rx_s_q;
  assign addr_hit = !ctrl_q[uart_pkg::CTL_ADDR_DET] || (r9_q && rsr_q[7:0] == addr_q);
  assign rx_ok_d  = rx_done && addr_hit;

  // Two-stage synchroniser on the asynchronous line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else begin
      rx_m_q <= rxd;
      rx_s_q <= rx_m_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q   <= uart_pkg::S_IDLE;
      rsr_q   <= '0;
      rtick_q <= '0;
      rbit_q  <= '0;
      rpar_q  <= 1'b0;
      r9_q    <= 1'b0;
    end else begin
      if (tick) rtick_q <= rtick_q + 4'h1;
      case (rst_q)
        uart_pkg::S_IDLE: if (!rx_s_q) begin
          rst_q   <= uart_pkg::S_START;
          rtick_q <= '0;
        end
        uart_pkg::S_START: if (rsamp) begin
          // A start that is gone at mid-bit is glitch noise.
          rst_q <= rx_s_q ? uart_pkg::S_IDLE : uart_pkg::S_DATA;
          rbit_q <= '0;
          rpar_q <= 1'b0;
          rsr_q  <= '0;
          r9_q   <= 1'b0;
        end
        uart_pkg::S_DATA: if (rsamp) begin
          rsr_q[rbit_q[2:0]] <= rx_s_q;
          rpar_q <= rpar_q ^ rx_s_q;
          rbit_q <= rbit_q + 4'h1;
          if (rbit_q + 4'h1 == cfg.len)
            rst_q <= cfg.par_en ? uart_pkg::S_PAR :
                     cfg.nine   ? uart_pkg::S_NINTH : uart_pkg::S_STOP;
        end
        uart_pkg::S_PAR: if (rsamp) begin
          rpar_q <= rpar_q ^ rx_s_q;
          rst_q  <= uart_pkg::S_STOP;
        end
        uart_pkg::S_NINTH: if (rsamp) begin
          r9_q     <= rx_s_q;
          rsr_q[8] <= rx_s_q;
          rst_q    <= uart_pkg::S_STOP;
        end
        uart_pkg::S_STOP: if (rsamp) rst_q <= uart_pkg::S_IDLE;
        default: rst_q <= uart_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rbr_q      <= '0;
      rbr_full_q <= 1'b0;
    end else if (rx_ok_d) begin
      rbr_q      <= rsr_q;
      rbr_full_q <= 1'b1;  // New data wins over a read.
    end else if (data_rd) begin
      rbr_full_q <= 1'b0;
    end
  end

  logic st_wr;
  assign st_wr = wr && (paddr == uart_pkg::OFF_STATUS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      oerr_q <= 1'b0;
    end else begin
      perr_q <= (rx_ok_d && pbad) || (perr_q && !(st_wr && pwdata[2]));
      ferr_q <= (rx_ok_d && fbad) || (ferr_q && !(st_wr && pwdata[3]));
      oerr_q <= (rx_ok_d && rbr_full_q && !data_rd) || (oerr_q && !(st_wr && pwdata[4]));
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts, configuration and APB answer
  // ----------------------------------------------------------------------
  // maskable events
  assign ev[uart_pkg::IRQ_TX_EMPTY] = tx_load;
  assign ev[uart_pkg::IRQ_RX_READY] = rx_ok_d;
  assign ev[uart_pkg::IRQ_RX_ERR]   = rx_ok_d && (pbad || fbad || rbr_full_q);
  logic ist_wr;
  assign ist_wr = wr && (paddr == uart_pkg::OFF_IRQ_ST);

  logic [31:0] rdata;
  always_comb begin
    rdata = '0;
    case (paddr)
      uart_pkg::OFF_DATA:    rdata = {23'h0, rbr_q};
      uart_pkg::OFF_DIV_LO:  rdata = {24'h0, div_lo_q};
      uart_pkg::OFF_DIV_HI:  rdata = {24'h0, div_hi_q};
      uart_pkg::OFF_CTRL:    rdata = {24'h0, ctrl_q};
      uart_pkg::OFF_STATUS:  rdata = {27'h0, oerr_q, ferr_q, perr_q, rbr_full_q, !thr_full_q};
      uart_pkg::OFF_IRQ_ST:  rdata = {29'h0, ist_q};
      uart_pkg::OFF_IRQ_MSK: rdata = {29'h0, imsk_q};
      uart_pkg::OFF_ADDR:    rdata = {24'h0, addr_q};
      default:               rdata = '0;
    endcase
  end

  // Zero-wait slave: pready answers in the access cycle.
  // Read data is captured at setup, so prdata stands only while pready is high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_lo_q <= uart_pkg::DIV_RESET[7:0];
      div_hi_q <= uart_pkg::DIV_RESET[15:8];
      addr_q   <= '0;
      ctrl_q   <= '0;
      ist_q    <= '0;
      imsk_q   <= '0;
      prdata   <= '0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      ist_q  <= ev | (ist_q & ~(ist_wr ? pwdata[uart_pkg::IRQ_W-1:0] : '0));
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rdata : '0;
      if (wr && paddr == uart_pkg::OFF_DIV_LO)  div_lo_q <= pwdata[7:0];
      if (wr && paddr == uart_pkg::OFF_DIV_HI)  div_hi_q <= pwdata[7:0];
      if (wr && paddr == uart_pkg::OFF_CTRL)    ctrl_q <= pwdata[uart_pkg::CTL_W-1:0];
      if (wr && paddr == uart_pkg::OFF_IRQ_MSK) imsk_q <= pwdata[uart_pkg::IRQ_W-1:0];
      if (wr && paddr == uart_pkg::OFF_ADDR)    addr_q <= pwdata[7:0];
    end
  end

  // Registered outputs.
  // Every pin leaves from a flop, so no decode glitch reaches the board.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd          <= 1'b1;
      irq          <= 1'b0;
      rx_level     <= 1'b1;
      dma_tx_req   <= 1'b0;
      dma_rx_req   <= 1'b0;
      dma_low_prio <= 1'b0;
    end else begin
      txd      <= txd_q;
      irq      <= |(ist_q & imsk_q);
      rx_level <= rx_s_q;
      dma_tx_req <= dma_mode && !thr_full_q && !data_wr;
      dma_rx_req <= dma_mode && rbr_full_q && !data_rd;
      dma_low_prio <= 1'b1;
    end
  end

endmodule : uart_port

// ==== uart_port_chk.sv ====
// Purpose: Concurrent checks on the serial port's bus and line pins.
// Assumes: Divisor kept at two or less whenever a transmit start is checked.
// Notes:   Bound to every instance of the port; sees only its pins.
`timescale 1ns/1ps
module uart_port_chk (
  // Bus side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Line side
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        dma_low_prio,
  input wire logic        rx_level
);
  logic [8:0] idle_q;
  logic [8:0] idle_d;

  // A long high run on txd proves the shifter and holding register are empty.
  assign idle_d = !txd ? 9'h000 : (idle_q == 9'h1ff ? idle_q : idle_q + 9'h001);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_q <= 9'h000;
    else idle_q <= idle_d;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence idle_wr_s;
    psel && penable && pready && pwrite && paddr == uart_pkg::OFF_DATA && idle_q > 9'h190;
  endsequence

  chk_ready_setup: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  chk_prio_low: assert property ($past(presetn) |-> dma_low_prio)
    else $error("priority flag low");
  chk_rx_sync: assert property ($past(presetn) && $past(presetn, 2) && $past(presetn, 3)
    |-> rx_level == $past(rxd, 3))
    else $error("receive level not three cycles behind");
  chk_tx_start: assert property (idle_wr_s |-> ##[1:8] !txd)
    else $error("no start bit after data write");
endmodule : uart_port_chk

bind uart_port uart_port_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
  .txd(txd), .dma_low_prio(dma_low_prio), .rx_level(rx_level));

// ==== remote_node.sv ====
// Purpose: Behavioural far-end node that sends and captures serial frames.
// Assumes: Bit length in clocks starts at 16; the bench sets it before each receive.
// Notes:   Frame bits after the start bit are handed over LSB first.
`timescale 1ns/1ps
module remote_node (
  // Clock
  input  wire logic pclk,
  // Serial lines
  input  wire logic txd,
  output logic      rxd
);
  int bit_clks = 16;

  initial rxd = 1'b1;

  // low start bit, the given bits, then the line idles high.
  task automatic send(input logic [11:0] bits, input int n);
    rxd <= 1'b0;
    repeat (bit_clks) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (bit_clks) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask : send

  // find the falling edge, then sample each bit at its middle.
  task automatic recv(input int n, output logic [11:0] bits, output bit ok);
    int k;
    bits = '1;
    k = 0;
    while (txd !== 1'b0 && k < 4000) begin
      @(posedge pclk);
      k++;
    end
    repeat (bit_clks / 2) @(posedge pclk);
    ok = (k < 4000) && (txd === 1'b0);
    for (int i = 0; i < n; i++) begin
      repeat (bit_clks) @(posedge pclk);
      bits[i] = txd;
    end
  endtask : recv
endmodule : remote_node

// ==== testbench.sv ====
// Purpose: Self-checking bench for the serial port over its APB registers.
// Assumes: Divisor one or two, so a bit lasts 16 or 32 clocks.
// Notes:   Expected frames are built here from the control settings.
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, rxd, txd, pready, pslverr;
  logic        dma_tx_req, dma_rx_req, dma_low_prio, rx_level, irq, ok;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] fb, got;
  int          fn, err_count, cmp_count;
  // Transmit cases: control byte, character and divisor of each frame.
  logic [7:0]  cfg [5] = '{8'h0b, 8'h1c, 8'h02, 8'h23, 8'h00};
  logic [8:0]  dat [5] = '{9'h055, 9'h013, 9'h041, 9'h1a5, 9'h00a};
  logic [15:0] dvs [5] = '{16'h0002, 16'h0001, 16'h0001, 16'h0001, 16'h0001};

  uart_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .dma_low_prio(dma_low_prio),
    .rx_level(rx_level), .irq(irq));
  remote_node i_node (.pclk(pclk), .txd(txd), .rxd(rxd));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    ok = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      err_count++;
      summarize();
    end
  endtask : apb

  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      apb(0, uart_pkg::OFF_STATUS, 32'h0);
      k++;
    end while (rd[b] !== 1'b1 && k < 100);
    check("status bit", rd[b], 32'h1);
    if (rd[b] !== 1'b1) summarize();
  endtask : poll

  // Frame bits after the start bit; parity wins over the ninth bit.
  task automatic build(input logic [7:0] c, input logic [8:0] d);
    logic p;
    p = c[4];
    fn = 0;
    fb = '1;
    for (int i = 0; i < 5 + c[1:0]; i++) begin
      fb[fn] = d[i];
      p ^= d[i];
      fn++;
    end
    if (c[3]) fb[fn] = p;
    else if (c[5]) fb[fn] = d[8];
    fn += (c[3] || c[5]) + (c[2] ? 2 : 1);
  endtask : build

  task automatic tx_case(input logic [7:0] c, input logic [8:0] d, input logic [15:0] dv);
    apb(1, uart_pkg::OFF_DIV_LO, {24'h0, dv[7:0]});
    apb(1, uart_pkg::OFF_CTRL, {24'h0, c});
    build(c, d);
    i_node.bit_clks = 16 * dv;
    fork
      apb(1, uart_pkg::OFF_DATA, {23'h0, d});
      i_node.recv(fn, got, ok);
    join
    check("tx start bit", ok, 32'h1);
    check("tx frame", {20'h0, got}, {20'h0, fb});
  endtask : tx_case

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, uart_pkg::OFF_DIV_LO, 32'h0);
    check("divisor low reset", rd, 32'h1);
    apb(0, uart_pkg::OFF_STATUS, 32'h0);
    check("status reset", rd, 32'h1);
    check("dma priority", dma_low_prio, 32'h1);
    apb(1, uart_pkg::OFF_DIV_HI, 32'ha5);
    apb(0, uart_pkg::OFF_DIV_HI, 32'h0);
    check("divisor high", rd, 32'ha5);
    apb(1, uart_pkg::OFF_DIV_HI, 32'h0);
    apb(0, 8'h20, 32'h0);
    check("unmapped error", ok, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1, uart_pkg::OFF_CTRL, 32'h3);
    build(8'h03, 9'h0a3);
    i_node.send(fb, fn);
    poll(1);
    check("irq masked", irq, 32'h0);
    apb(0, uart_pkg::OFF_IRQ_ST, 32'h0);
    check("irq status", rd, 32'h2);
    apb(1, uart_pkg::OFF_IRQ_MSK, 32'h2);
    apb(0, uart_pkg::OFF_DATA, 32'h0);
    check("rx data", rd, 32'ha3);
    check("irq raised", irq, 32'h1);
    apb(1, uart_pkg::OFF_IRQ_ST, 32'h2);
    apb(0, uart_pkg::OFF_STATUS, 32'h0);
    check("rx ready cleared", rd, 32'h1);
    check("irq cleared", irq, 32'h0);
    apb(1, uart_pkg::OFF_CTRL, 32'h0b);
    build(8'h0b, 9'h0a3);
    fb[8] = ~fb[8];
    i_node.send(fb, fn);
    poll(2);
    apb(1, uart_pkg::OFF_CTRL, 32'h3);
    build(8'h03, 9'h0f0);
    fb[8] = 1'b0;
    i_node.send(fb, fn);
    poll(3);
    for (int i = 0; i < 5; i++) tx_case(cfg[i], dat[i], dvs[i]);
    apb(0, uart_pkg::OFF_IRQ_ST, 32'h0);
    check("tx irq", rd[0], 32'h1);
    apb(1, uart_pkg::OFF_CTRL, 32'h43);
    apb(0, uart_pkg::OFF_STATUS, 32'h0);
    check("dma tx request", dma_tx_req, 32'h1);
    // Address detect in DMA mode: a data character is dropped, an address match is kept.
    apb(0, uart_pkg::OFF_DATA, 32'h0);
    apb(1, uart_pkg::OFF_ADDR, 32'h5a);
    apb(1, uart_pkg::OFF_CTRL, 32'he3);
    build(8'h23, 9'h05a);
    i_node.send(fb, fn);
    apb(0, uart_pkg::OFF_STATUS, 32'h0);
    check("address filter", rd[1], 32'h0);
    check("dma rx idle", dma_rx_req, 32'h0);
    build(8'h23, 9'h15a);
    i_node.send(fb, fn);
    poll(1);
    check("dma rx request", dma_rx_req, 32'h1);
    check("dma tx still empty", dma_tx_req, 32'h1);
    apb(0, uart_pkg::OFF_DATA, 32'h0);
    check("address char", rd, 32'h15a);
    apb(0, uart_pkg::OFF_STATUS, 32'h0);
    check("rx drained", rd[1], 32'h0);
    check("dma rx served", dma_rx_req, 32'h0);
    summarize();
  end
endmodule : testbench
